// *** hw/dual_comparator_control.sv ***
// apb slave and control logic of the two-comparator module
// assumes analog comparators outside; results arrive asynchronously
//
// The placing of the registers and register access over APB were decided locally.
`timescale 1ns/10ps
`default_nettype none
module dual_comparator_control (
   // clock, reset and freeze
   input  wire logic        pclk,
   input  wire logic        presetn,
   input  wire logic        clk_en,

   // register bus
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [11:0] paddr,
   input  wire logic [31:0] pwdata,
   output logic      [31:0] prdata,
   output logic             pready,
   output logic             pslverr,

   // raw comparator results
   input  wire logic        cmp1_raw,
   input  wire logic        cmp2_raw,

   // results at register side and pins
   output logic             cmp1_result,
   output logic             cmp2_result,
   output logic             cmp1_result_pin,
   output logic             cmp2_result_pin,

   // analog routing
   output logic [2:0]       comparator_config,
   output logic             cmp_enable,
   output logic             vref_to_pos,
   output logic             cmp1_pos_pin_sel,
   output logic             cmp2_pos_pin_sel,
   output logic             cmp1_neg_pin_sel,
   output logic             cmp2_neg_pin_sel,

   // interrupt
   output logic             irq
);
   localparam int ncmp = 2;

   // control register fields; inversion bits live per comparator
   logic [2:0]           mode_q;
   logic [2:0]           mode_d;
   logic                 switch_q;
   logic                 switch_d;

   // change flag and its enable
   logic                 flag_q;
   logic                 flag_d;
   logic                 enable_q;
   logic                 enable_d;

   // read data
   logic [31:0]          prdata_q;
   logic [31:0]          prdata_d;

   // bus decode
   wire logic            access;
   wire logic            wr;
   wire logic            rd_setup;
   wire logic            hit_ctrl;
   wire logic            hit_status;
   wire logic            hit_enable;
   wire logic            hit_clear;
   wire logic            mapped;
   wire logic            ctrl_access;
   wire logic            ctrl_write;
   wire logic            enable_write;
   wire logic            clear_write;

   // mode decode
   wire logic            muxed;
   wire logic            mode_is_reset;
   wire logic            mode_is_off;
   wire logic            cmp_on;

   // per comparator, bit 0 is comparator 1
   wire logic [ncmp-1:0] raw_vec;
   wire logic [ncmp-1:0] inv_vec;
   wire logic [ncmp-1:0] res_vec;
   wire logic [ncmp-1:0] out_vec;
   wire logic [ncmp-1:0] pin_vec;
   wire logic [ncmp-1:0] pos_sel_vec;
   wire logic [ncmp-1:0] neg_sel_vec;
   wire logic [ncmp-1:0] changed_vec;

   // flag and readback
   wire logic            flag_set;
   wire logic            flag_clear;
   wire logic [7:0]      ctrl_rd;
   wire logic [31:0]     status_rd;
   wire logic [31:0]     enable_rd;
   wire logic [31:0]     rd_mux;

   assign access       = psel & penable & clk_en;
   assign wr           = access & pwrite;
   assign rd_setup     = psel & ~penable & ~pwrite;

   assign hit_ctrl     = paddr == cmp_ctrl_pkg::ctrl_offset;
   assign hit_status   = paddr == cmp_ctrl_pkg::status_offset;
   assign hit_enable   = paddr == cmp_ctrl_pkg::enable_offset;
   assign hit_clear    = paddr == cmp_ctrl_pkg::clear_offset;
   assign mapped       = hit_ctrl | hit_status
                         | hit_enable | hit_clear;

   assign ctrl_access  = access & hit_ctrl;
   assign ctrl_write   = wr & hit_ctrl;
   assign enable_write = wr & hit_enable;
   assign clear_write  = wr & hit_clear;

   assign muxed         = mode_q == cmp_ctrl_pkg::mode_muxed;
   assign mode_is_reset = mode_q == cmp_ctrl_pkg::mode_reset;
   assign mode_is_off   = mode_q == cmp_ctrl_pkg::mode_off;
   // powered down in the reset mode, the off mode and during reset
   assign cmp_on        = presetn & ~mode_is_reset
                          & ~mode_is_off;

   assign raw_vec = {cmp2_raw, cmp1_raw};

   // one synchroniser, polarity stage and change detector per comparator
   generate
      for (genvar i = 0; i < ncmp; i++) begin : g_cmp
         logic first_q;
         logic first_d;
         logic second_q;
         logic second_d;

         logic inv_q;
         logic inv_d;
         logic latched_q;
         logic latched_d;

         logic out_q;
         logic out_d;

         assign first_d        = raw_vec[i];
         assign second_d       = first_q;
         assign inv_vec[i]     = inv_q;
         assign inv_d          = ctrl_write ? pwdata[cmp_ctrl_pkg::inv1_bit + i]
                                            : inv_q;
         // pins see the raw result, software the synchronised one
         assign pin_vec[i]     = raw_vec[i] ^ inv_q;
         assign res_vec[i]     = second_q ^ inv_q;
         assign out_d          = res_vec[i];
         assign out_vec[i]     = out_q;

         assign latched_d      = ctrl_access ? res_vec[i] : latched_q;
         assign changed_vec[i] = res_vec[i] != latched_q;
         // the switch does nothing outside the multiplexed mode
         assign pos_sel_vec[i] = muxed & switch_q;
         assign neg_sel_vec[i] = muxed & ~switch_q;

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               first_q <= 1'b0;
            end
            else if (clk_en) begin
               first_q <= first_d;
            end
         end

         // only the second stage reads the first
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               second_q <= 1'b0;
            end
            else if (clk_en) begin
               second_q <= second_d;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               inv_q <= 1'b0;
            end
            else if (clk_en) begin
               inv_q <= inv_d;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               latched_q <= 1'b0;
            end
            else if (clk_en) begin
               latched_q <= latched_d;
            end
         end

         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               out_q <= 1'b0;
            end
            else if (clk_en) begin
               out_q <= out_d;
            end
         end
      end
   endgenerate

   assign flag_set   = |changed_vec;
   assign flag_clear = clear_write & pwdata[0];
   // set wins over clear
   assign flag_d     = flag_set ? 1'b1 :
                       flag_clear ? 1'b0 : flag_q;
   assign enable_d   = enable_write ? pwdata[0] : enable_q;

   assign mode_d   = ctrl_write ? pwdata[2:0] : mode_q;
   assign switch_d = ctrl_write ? pwdata[cmp_ctrl_pkg::switch_bit]
                                : switch_q;

   // result bits are not stored, so writes to them are lost
   assign ctrl_rd   = {res_vec, inv_vec, switch_q, mode_q};
   assign status_rd = {31'h00000000, flag_q};
   assign enable_rd = {31'h00000000, enable_q};
   assign rd_mux    = hit_ctrl   ? {24'h000000, ctrl_rd} :
                      hit_status ? status_rd :
                      hit_enable ? enable_rd : 32'h00000000;
   // read data is captured in the setup cycle
   assign prdata_d  = rd_setup ? rd_mux : prdata_q;

   assign prdata            = prdata_q;
   assign pready            = 1'b1;
   assign pslverr           = psel & penable & ~mapped;
   assign irq               = flag_q & enable_q;

   assign comparator_config = mode_q;
   assign cmp_enable        = cmp_on;
   assign vref_to_pos       = muxed;

   // both comparators switch together
   assign cmp1_pos_pin_sel  = pos_sel_vec[0];
   assign cmp2_pos_pin_sel  = pos_sel_vec[1];
   assign cmp1_neg_pin_sel  = neg_sel_vec[0];
   assign cmp2_neg_pin_sel  = neg_sel_vec[1];

   assign cmp1_result_pin   = pin_vec[0];
   assign cmp2_result_pin   = pin_vec[1];
   assign cmp1_result       = out_vec[0];
   assign cmp2_result       = out_vec[1];

   // mode field
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         mode_q <= cmp_ctrl_pkg::mode_reset;
      end
      else if (clk_en) begin
         mode_q <= mode_d;
      end
   end

   // input switch
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         switch_q <= 1'b0;
      end
      else if (clk_en) begin
         switch_q <= switch_d;
      end
   end

   // change flag
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         flag_q <= 1'b0;
      end
      else if (clk_en) begin
         flag_q <= flag_d;
      end
   end

   // interrupt enable
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         enable_q <= 1'b0;
      end
      else if (clk_en) begin
         enable_q <= enable_d;
      end
   end

   // read data
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         prdata_q <= 32'h00000000;
      end
      else if (clk_en) begin
         prdata_q <= prdata_d;
      end
   end

endmodule
`default_nettype wire

// *** include/cmp_ctrl_pkg.sv ***
// constants for the dual comparator control block
// assumes an apb master with 32-bit data on pclk
// What this block does
// - two comparators, inputs from six pins and reference
// - results, optionally inverted, at pins and register
// - bit 7 reports comparator 2 result
// - bit 6 reports comparator 1 result
// - bit 5 inverts comparator 2
// - bit 4 inverts comparator 1
// - input switch acts only in mode 110
// - bits 2..0 select configuration mode
// - result bits read-only, lower six writable, reset zero
// - reset gives mode 000, comparators powered down
// - output change since last control register access sets flag, kept until a clear write
// - mode 111 off; reference only in mode 110
package cmp_ctrl_pkg;
   localparam logic [11:0] ctrl_offset   = 12'h000;
   localparam logic [11:0] status_offset = 12'h004;
   localparam logic [11:0] enable_offset = 12'h008;
   localparam logic [11:0] clear_offset  = 12'h00C;
   localparam int          out2_bit      = 7;
   localparam int          out1_bit      = 6;
   localparam int          inv2_bit      = 5;
   localparam int          inv1_bit      = 4;
   localparam int          switch_bit    = 3;
   localparam logic [7:0]  ctrl_reset    = 8'h00;
   localparam logic [5:0]  wr_mask_reset = 6'h00;
   localparam logic [2:0]  mode_reset    = 3'h0;
   localparam logic [2:0]  mode_muxed    = 3'h6;
   localparam logic [2:0]  mode_off      = 3'h7;
endpackage

// *** tb/cmp_analog_model.sv ***
// far side: two comparators on a bench level
// assumes level holds the pos>neg outcomes
`timescale 1ns/10ps
`default_nettype none
module cmp_analog_model (
   input  wire logic       cmp_enable,
   input  wire logic [1:0] level,
   output logic            cmp1_raw,
   output logic            cmp2_raw
);
   // powered down reads low; delay keeps edges async
   assign #3 {cmp2_raw, cmp1_raw} = cmp_enable ? level : 2'h0;
endmodule
`default_nettype wire

// *** tb/cmp_ctrl_properties.sv ***
// mode and routing checks
// bound from the bench top
`timescale 1ns/10ps
`default_nettype none
module cmp_ctrl_properties (
   input wire logic       pclk,
   input wire logic       presetn,
   input wire logic       cmp_enable,
   input wire logic       vref_to_pos,
   input wire logic       cmp1_pos_pin_sel,
   input wire logic       cmp1_neg_pin_sel,
   input wire logic [2:0] comparator_config
);
   wire logic [2:0] md = comparator_config;
   default clocking @(posedge pclk);
   endclocking
   default disable iff (!presetn);
   AST_OFF: assert property (md == 3'h7 |-> !cmp_enable) else $error("on in mode 7");
   AST_RST: assert property (md == 3'h0 |-> !cmp_enable) else $error("on in mode 0");
   AST_ON: assert property (md inside {[3'h1:3'h6]} |-> cmp_enable) else $error("off");
   AST_REF: assert property (vref_to_pos == (md == 3'h6)) else $error("vref");
   AST_POS: assert property (cmp1_pos_pin_sel |-> md == 3'h6) else $error("pos");
   AST_NEG: assert property (cmp1_neg_pin_sel |-> md == 3'h6) else $error("neg");
   AST_MUX: assert property (md == 3'h6 |-> cmp1_pos_pin_sel ^ cmp1_neg_pin_sel)
      else $error("mux");
   AST_VON: assert property (vref_to_pos |-> cmp_enable) else $error("vref off");
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// bench: apb driver with read notes and monitor
// assumes model and checker compiled first
`timescale 1ns/10ps
`default_nettype none
module tb;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, pready, pslverr, irq;
   logic cmp1_raw, cmp2_raw, cmp_enable, vref_to_pos, cmp1_result, cmp2_result, cmp1_result_pin;
   logic cmp2_result_pin, cmp1_pos_pin_sel, cmp2_pos_pin_sel, cmp1_neg_pin_sel, cmp2_neg_pin_sel;
   logic [1:0] level = 0;
   logic clk_en = 1;
   logic [2:0] comparator_config;
   logic [11:0] paddr = 0;
   logic [31:0] pwdata = 0, prdata, v;
   logic [33:0] note_q[$];
   int err_count = 0, tests_run = 0, cyc = 0;
   always #10 pclk = ~pclk;
   dual_comparator_control dut(.*);
   cmp_analog_model far(.*);
   task bus(input logic w, logic [11:0] a, logic [31:0] d, logic [33:0] e = 0);
      if (!w) note_q.push_back(e);
      {psel, pwrite, paddr, pwdata} <= {1'h1, w, a, d};
      @(posedge pclk) penable <= 1;
      do @(posedge pclk); while (pready !== 1'h1);
      {psel, penable} <= 2'h0;
      @(posedge pclk);
   endtask
   task check(input logic [33:0] e, g);
      tests_run++;
      err_count += 32'(g !== e);
      if (g !== e) $display("BAD read %h exp %h got %h", paddr, e, g);
   endtask
   task stop_test;
      $display("checks %0d errors %0d", tests_run, err_count);
      if (err_count == 0 && tests_run > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask
   always @(posedge pclk) begin
      if (psel && penable && pready && !pwrite) check(note_q.pop_front(), {irq, pslverr, prdata});
      if (++cyc > 2000) err_count++;
      if (cyc > 2000) stop_test();
   end
   initial begin
      void'($urandom(32'h1F425E0B));
      repeat (16) @(posedge pclk);
      presetn <= 1;
      bus(0, 0, 0, 0);
      for (int i = 0; i < 8; i++) begin
         v = $urandom << 3 | 32'(i);
         level <= 2'($urandom);
         bus(1, 0, v);
         repeat (6) @(posedge pclk);
         bus(0, 0, 0, {level & {2{i % 7 != 0}} ^ v[5:4], v[5:0]});
      end
      bus(1, 12'h8, 1);
      bus(1, 12'hC, 1);
      bus(0, 12'h4, 0, 0);
      level <= ~v[5:4];
      bus(1, 0, 1);
      repeat (6) @(posedge pclk);
      bus(0, 12'h4, 0, 34'h200000001);
      clk_en <= 0;
      bus(1, 12'h8, 0);
      clk_en <= 1;
      bus(0, 12'h10, 0, 34'h300000000);
      stop_test();
   end
endmodule
bind dual_comparator_control cmp_ctrl_properties chk(.*);
`default_nettype wire
